/* File: core/epsw_consts.svh */
/*
  Constants for the e-paper serial write port: bit counts per transfer and synchroniser depth.
  Assumes inclusion by bare name from the package and the port module.
*/
`ifndef EPSW_CONSTS_SVH
`define EPSW_CONSTS_SVH

// Data bits per byte
`define EPSW_BYTE_BITS 4'h8
// Bits per frame in three-wire mode (flag plus byte)
`define EPSW_NINE_BITS 4'h9
// Bits per frame in four-wire mode
`define EPSW_FOUR_BITS 4'h8
// Synchroniser depth for pin inputs
`define EPSW_SYNC_DEPTH 3

`endif

/* File: core/epsw_pkg.sv */
/*
  Types for the e-paper serial write port.
  Assumes the constants header sits beside it.
*/
`include "epsw_consts.svh"

package epsw_pkg;

  // Destination of a completed byte
  typedef enum logic {
    EPSW_DEST_CMD,
    EPSW_DEST_RAM
  } epsw_dest_t;

  // One committed byte with its destination
  typedef struct packed {
    logic isData;
    logic [7:0] byteVal;
  } epsw_word_t;

  // Serial pins after synchronisation
  typedef struct packed {
    logic chipSelectN;
    logic serialClk;
    logic serialData;
    logic cmdDataSelect;
  } epsw_pins_t;

endpackage

/* File: core/epsw_port.sv */
/*
  Write-only serial host port of an e-paper panel controller.
  Samples the host serial pins on the system clock (40 MHz), finds serial
  clock edges, assembles bytes and presents each as a one-cycle strobe
  toward the command register or the display RAM.
  Assumes the serial clock period is at least eight system clocks.
*/
`timescale 1ns/1ps
`include "epsw_consts.svh"

// Operation
// - Strap low four-wire, high three-wire nine-bit
// - Four-wire: sample on rising clock, select marks
// - Shift eight bits, most significant first
// - Commit byte on its completing edge
// - Write only, never drive data back
// - Three-wire mode ignores select pin
// - Three-wire: flag bit then eight bits
// - Flag one to RAM, zero to command
module epsw_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select_strap,
  input wire logic chip_select_n,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic cmd_data_select,
  output logic cmdWrite,
  output logic ramWrite,
  output logic [7:0] writeByte,
  output logic three_wire_mode,
  output logic dataOut,
  output logic dataOutEn
);

  // Three-stage synchronisers, one per pin
  logic [2:0] strapSync_reg;
  logic [2:0] csSync_reg;
  logic [2:0] sclSync_reg;
  logic [2:0] sdaSync_reg;
  logic [2:0] selSync_reg;

  // Agreed (stable) pin levels
  logic strapStable_reg;
  logic csStable_reg;
  logic sclStable_reg;
  logic sdaStable_reg;
  logic selStable_reg;

  // Shift register and bit counter
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bitCount_reg;
  logic [3:0] bitCount_next;
  logic flag_reg;
  logic flag_next;

  // Output registers
  epsw_pkg::epsw_word_t word_reg;
  logic cmdWrite_reg;
  logic ramWrite_reg;
  logic mode_reg;

  // Synchroniser chains: first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapSync_reg <= 3'h0;
      csSync_reg <= 3'h7;
      sclSync_reg <= 3'h0;
      sdaSync_reg <= 3'h0;
      selSync_reg <= 3'h0;
    end else begin
      strapSync_reg <= {strapSync_reg[1:0], interface_select_strap};
      csSync_reg <= {csSync_reg[1:0], chip_select_n};
      sclSync_reg <= {sclSync_reg[1:0], serialClk};
      sdaSync_reg <= {sdaSync_reg[1:0], serialData};
      selSync_reg <= {selSync_reg[1:0], cmd_data_select};
    end
  end

  // A level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapStable_reg <= 1'b0;
      csStable_reg <= 1'b1;
      sclStable_reg <= 1'b0;
      sdaStable_reg <= 1'b0;
      selStable_reg <= 1'b0;
    end else begin
      if (strapSync_reg[1] == strapSync_reg[2]) begin
        strapStable_reg <= strapSync_reg[2];
      end
      if (csSync_reg[1] == csSync_reg[2]) begin
        csStable_reg <= csSync_reg[2];
      end
      if (sclSync_reg[1] == sclSync_reg[2]) begin
        sclStable_reg <= sclSync_reg[2];
      end
      if (sdaSync_reg[1] == sdaSync_reg[2]) begin
        sdaStable_reg <= sdaSync_reg[2];
      end
      if (selSync_reg[1] == selSync_reg[2]) begin
        selStable_reg <= selSync_reg[2];
      end
    end
  end

  // Rising serial clock seen while selected; data sampled with it
  wire sclAgree = (sclSync_reg[1] == sclSync_reg[2]);
  wire sclRise = sclAgree & sclSync_reg[2] & ~sclStable_reg;
  wire selected = ~csStable_reg;
  wire bitTake = sclRise & selected;
  wire threeWire = mode_reg;
  wire [3:0] frameBits = threeWire ? `EPSW_NINE_BITS
                                   : `EPSW_FOUR_BITS;
  wire lastBit = (bitCount_reg == frameBits - 4'h1);
  wire flagSlot = threeWire & (bitCount_reg == 4'h0);
  // Three-wire uses the flag bit, four-wire the select pin
  wire destData = threeWire ? flag_reg : selStable_reg;
  wire [7:0] fullByte = {shift_reg[6:0], sdaStable_reg};

  // Next-state for shifter and counter
  always_comb begin
    shift_next = shift_reg;
    bitCount_next = bitCount_reg;
    flag_next = flag_reg;
    if (!selected) begin
      // Deselect drops partial byte
      bitCount_next = 4'h0;
      shift_next = 8'h00;
    end else if (bitTake) begin
      if (flagSlot) begin
        // Leading flag bit
        flag_next = sdaStable_reg;
      end else begin
        shift_next = fullByte;
      end
      bitCount_next = lastBit ? 4'h0 : bitCount_reg + 4'h1;
    end
  end

  // Mode is caught from the strap on every cycle while deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 1'b0;
    end else if (!selected) begin
      mode_reg <= strapStable_reg;
    end
  end

  // Shifter state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
      bitCount_reg <= 4'h0;
      flag_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      bitCount_reg <= bitCount_next;
      flag_reg <= flag_next;
    end
  end

  // Commit on the edge finishing the byte
  wire commit = bitTake & lastBit;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= '0;
      cmdWrite_reg <= 1'b0;
      ramWrite_reg <= 1'b0;
    end else begin
      cmdWrite_reg <= commit & ~destData;
      ramWrite_reg <= commit & destData;
      if (commit) begin
        word_reg.byteVal <= fullByte;
        word_reg.isData <= destData;
      end
    end
  end

  assign cmdWrite = cmdWrite_reg;
  assign ramWrite = ramWrite_reg;
  assign writeByte = word_reg.byteVal;
  assign three_wire_mode = mode_reg;

  // Serial data is never driven back
  logic dataOut_reg;
  logic dataOutEn_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut_reg <= 1'b0;
      dataOutEn_reg <= 1'b0;
    end else begin
      dataOut_reg <= 1'b0;
      dataOutEn_reg <= 1'b0;
    end
  end
  assign dataOut = dataOut_reg;
  assign dataOutEn = dataOutEn_reg;

  // Assertions
  no_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dataOutEn) else $error("serial data driven");
  one_dest_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(cmdWrite && ramWrite)) else $error("two destinations");
  commit_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    commit |=> (cmdWrite || ramWrite)) else $error("commit lost");
  strobe_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cmdWrite || ramWrite) |-> $past(bitTake)) else $error("stray strobe");
  desel_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    !selected |=> bitCount_reg == 4'h0) else $error("count kept");
  four_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    !threeWire |-> bitCount_reg < `EPSW_FOUR_BITS)
    else $error("four-wire overrun");
  nine_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    bitCount_reg < `EPSW_NINE_BITS) else $error("count overrun");
  ram_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (commit && threeWire && flag_reg) |=> ramWrite)
    else $error("flag not routed to RAM");
  msb_first_a: assert property (@(posedge clk) disable iff (!rst_n)
    (bitTake && selected && !flagSlot) |=>
      shift_reg[0] == $past(sdaStable_reg))
    else $error("bit order wrong");
  sel_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
    (commit && threeWire && !flag_reg) |=> cmdWrite)
    else $error("select pin used in three-wire");
  mode_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
    selected |=> $stable(mode_reg)) else $error("mode changed in frame");

endmodule

/* File: dv/epsw_host_model.sv */
/*
  Host model: drives write frames on the serial pins.
  Assumes the port samples the pins on the same system clock.
*/
`timescale 1ns/1ps
module epsw_host_model (
  input wire logic clk,
  output logic csN,
  output logic sck,
  output logic sda,
  output logic cmdDataSel
);
  // Idle pins; serial clock stands low
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    sda = 1'b0;
    cmdDataSel = 1'b0;
  end
  // Wait n system clocks
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data set in low phase, rising edge, high phase
  task automatic sendBit(input logic b);
    sda <= b;
    hold(4);
    sck <= 1'b1;
    hold(4);
    sck <= 1'b0;
  endtask
  // Write-only frame, flag first in three-wire, stops after nBits
  task automatic sendFrame(input logic three, input logic isData,
      input logic [7:0] val, input int nBits);
    logic [8:0] bits;
    int total;
    bits = {isData, val};
    total = three ? 9 : 8;
    hold(1);
    csN <= 1'b0;
    cmdDataSel <= three ? ~isData : isData;
    for (int i = 0; i < nBits && i < total; i++) begin
      sendBit(bits[total-1-i]);
    end
    hold(4);
    csN <= 1'b1;
    sda <= ~sda; // Released line shows no stale value
    hold(8);
  endtask
endmodule

/* File: dv/epsw_port_tb.sv */
/*
  Bench for the serial write port: host frames in, commits checked.
  Assumes the package, port and host model are compiled first.
*/
`timescale 1ns/1ps
`define EPSW_CHK(got, exp) checkVal(9'(got), 9'(exp))
module epsw_port_tb;
  logic clk = 1'b0; // System clock
  logic rst_n = 1'b0; // Reset, active low
  logic strap = 1'b0; // Mode strap
  wire csN, sck, sda, cmdDataSel; // Host pins
  logic cmdWrite, ramWrite, three_wire_mode, dataOut, dataOutEn;
  logic [7:0] writeByte; // Committed byte
  epsw_pkg::epsw_word_t gotWord = '0; // Last commit seen
  int strobes = 0; // Commits seen
  int expStrobes = 0; // Commits expected
  int fails = 0;
  int check_count = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  epsw_host_model epsw_host_model_inst (.clk(clk), .csN(csN),
    .sck(sck), .sda(sda), .cmdDataSel(cmdDataSel));
  epsw_port epsw_port_inst (.clk(clk), .rst_n(rst_n),
    .interface_select_strap(strap), .chip_select_n(csN),
    .serialClk(sck), .serialData(sda), .cmd_data_select(cmdDataSel),
    .cmdWrite(cmdWrite), .ramWrite(ramWrite), .writeByte(writeByte),
    .three_wire_mode(three_wire_mode), .dataOut(dataOut),
    .dataOutEn(dataOutEn));
  // Capture each commit strobe mid-cycle, where it stands settled
  always @(negedge clk) begin
    if (cmdWrite === 1'b1 || ramWrite === 1'b1) begin
      gotWord <= {ramWrite, writeByte};
      strobes <= strobes + 1;
    end
  end
  // Compare and count
  task automatic checkVal(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One frame, then bounded wait for the expected commit count
  task automatic frame(input logic three, input logic isData,
      input logic [7:0] val, input int nBits, input logic commits);
    int n;
    epsw_host_model_inst.sendFrame(three, isData, val, nBits);
    if (commits) begin
      expStrobes++;
    end
    @(negedge clk);
    for (n = 0; strobes != expStrobes && n < 60; n++) begin
      @(negedge clk);
    end
    if (n == 60) begin
      fails++;
      stop_test();
    end else begin
      `EPSW_CHK(strobes, expStrobes);
    end
  endtask
  // Four-wire command then data, back to back
  task automatic testFourWire();
    `EPSW_CHK(three_wire_mode, 1'b0);
    frame(1'b0, 1'b0, 8'ha5, 8, 1'b1);
    `EPSW_CHK(gotWord, 9'h0a5);
    frame(1'b0, 1'b1, 8'h3c, 8, 1'b1);
    `EPSW_CHK(gotWord, 9'h13c);
    $display("four wire test done");
  endtask
  // Partial byte dropped at deselect
  task automatic testAbort();
    frame(1'b0, 1'b1, 8'hff, 5, 1'b0);
    frame(1'b0, 1'b0, 8'h81, 8, 1'b1);
    `EPSW_CHK(gotWord, 9'h081);
    $display("abort test done");
  endtask
  // Three-wire flag routing, select pin driven against flag
  task automatic testThreeWire();
    @(posedge clk);
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    `EPSW_CHK(three_wire_mode, 1'b1);
    frame(1'b1, 1'b1, 8'h5a, 9, 1'b1);
    `EPSW_CHK(gotWord, 9'h15a);
    frame(1'b1, 1'b0, 8'hc3, 8, 1'b0);
    frame(1'b1, 1'b0, 8'hc3, 9, 1'b1);
    `EPSW_CHK(gotWord, 9'h0c3);
    `EPSW_CHK({dataOut, dataOutEn}, 2'b00);
    $display("three wire test done");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    testFourWire();
    testAbort();
    testThreeWire();
    stop_test();
  end
endmodule
